// ---- logic/pin_function_enable_pkg.sv ----
// constants of the system reset and nmi vector unit
// assumes a 16-bit cpu peripheral bus with byte addresses
package pin_function_enable_pkg;
  // ==========================================================
  // register offsets on the peripheral bus
  localparam logic [15:0] BUS_ERR_OFS = 16'h0198;
  localparam logic [15:0] USER_OFS    = 16'h019a;
  localparam logic [15:0] SYS_OFS     = 16'h019c;
  localparam logic [15:0] RST_OFS     = 16'h019e;
  localparam logic [15:0] CTRL_OFS    = 16'h0190;
  localparam logic [15:0] PIN_OFS     = 16'h0192;
  localparam logic [15:0] MBIN_OFS    = 16'h0194;
  localparam logic [15:0] MBOUT_OFS   = 16'h0196;
  // ==========================================================
  // reset sources, index i reports code 2*(i+1)
  localparam int          RST_SRC_N  = 11;
  localparam int          SRC_SVSIN  = 1;
  localparam int          SRC_PIN    = 2;
  localparam int          SRC_SWBOR  = 3;
  localparam int          SRC_SWPOR  = 5;
  localparam logic [10:0] BOR_MASK   = 11'h01f;
  localparam logic [10:0] POR_MASK   = 11'h020;
  localparam logic [10:0] PUC_MASK   = 11'h7c0;
  // ==========================================================
  // system and user nmi flag positions
  localparam int SYS_SUPPLY = 0;
  localparam int SYS_VACANT = 1;
  localparam int SYS_MBIN   = 2;
  localparam int SYS_MBOUT  = 3;
  localparam int USR_PIN    = 0;
  localparam int USR_OSC    = 1;
  localparam int USR_BUS    = 2;
  // ==========================================================
  // control and pin register fields, reset values
  localparam int         CTRL_LOCK  = 0;
  localparam int         CTRL_SWBOR = 1;
  localparam int         CTRL_SWPOR = 2;
  localparam int         PIN_NMI_EN = 0;
  localparam int         PIN_EDGE   = 1;
  localparam int         PIN_SVMOUT = 2;
  localparam int         PIN_SVSIN  = 3;
  localparam logic       LOCK_RST   = 1'b0;
  localparam logic [3:0] PIN_RST    = 4'h0;
  // ==========================================================
  // implemented memory ranges
  localparam logic [15:0] PERIPH_HI = 16'h0fff;
  localparam logic [15:0] LOCK_LO   = 16'h1c00;
  localparam logic [15:0] LOCK_HI   = 16'h237f;
  localparam logic [15:0] RAM_HI    = 16'h23ff;
  localparam logic [15:0] ROM_LO    = 16'hf800;
endpackage

// ---- logic/pin_sync.sv ----
// two-stage synchroniser for the reset/nmi pin with edge pulses
// assumes an asynchronous pin level and one clock domain
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic arst_n,
  // pin and synchronised view
  input  wire logic pin_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_reg;  // first stage, read only by the second
  logic sync_reg;  // settled level
  logic last_reg;  // previous settled level for edges

  // ==========================================================
  // registers idle high, matching an undriven pulled-up pin
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~last_reg;
  assign fall  = ~sync_reg & last_reg;
endmodule

// ---- logic/pin_function_enable_unit.sv ----
// system reset classing, nmi vectors, mailbox, pin and ram lock
// assumes event inputs are one-cycle pulses on mclk
`timescale 1ns/1ps
module pin_function_enable_unit (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // peripheral bus
  input  wire logic        per_en,
  input  wire logic        per_we,
  input  wire logic [15:0] per_addr,
  input  wire logic [15:0] per_wdata,
  output logic      [15:0] per_rdata,
  // cpu memory access watch
  input  wire logic        cpu_access,
  input  wire logic        cpu_write,
  input  wire logic [15:0] cpu_addr,
  output logic             wr_block,
  output logic             ram_locked,
  // event sources
  input  wire logic [10:0] reset_event,
  input  wire logic        supply_drop,
  input  wire logic        supply_low,
  input  wire logic        osc_fault,
  input  wire logic        bus_fault,
  // reset class requests
  output logic             bor_req,
  output logic             por_req,
  output logic             puc_req,
  // debugger mailbox
  input  wire logic        jtag_in_wr,
  input  wire logic [15:0] jtag_in_data,
  input  wire logic        jtag_out_rd,
  output logic      [15:0] jtag_out_data,
  // reset/nmi pin
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n
);
  // ==========================================================
  // helpers
  // code of the lowest set bit, lower index wins
  function automatic logic [15:0] first_code(input logic [10:0] p);
    first_code = 16'h0000;
    for (int i = pin_function_enable_pkg::RST_SRC_N - 1; i >= 0; i--) begin
      if (p[i]) begin
        first_code = 16'((i + 1) * 2);
      end
    end
  endfunction

  // one-hot of the lowest set bit
  function automatic logic [10:0] first_mask(input logic [10:0] p);
    return p & (~p + 11'h001);
  endfunction

  // ==========================================================
  // state
  logic [10:0] rst_reg, rst_next;    // pending reset sources
  logic [3:0]  sys_reg, sys_next;    // system nmi flags
  logic [2:0]  usr_reg, usr_next;    // user nmi flags
  logic        lock_reg, lock_next;  // ram lock bit
  logic [3:0]  pinc_reg, pinc_next;  // pin function bits
  logic [15:0] mbin_reg, mbin_next;  // debugger to application
  logic [15:0] mbout_reg, mbout_next;// application to debugger
  logic [15:0] rdata_reg, rdata_next;
  logic        bor_reg, por_reg, puc_reg;
  logic        bor_next, por_next, puc_next;
  logic        blk_reg, blk_next;
  logic        pout_reg, pout_next, poe_reg, poe_next;
  logic        pin_rise, pin_fall;       // raw pin edges
  logic [2:0]  own_reg, own_next;        // recent cycles we drove the pin
  logic        edge_rise, edge_fall;     // pin edges not of our own making
  logic [10:0] rst_set;
  logic        rd, wr, mapped, lockable;

  pin_sync pin_sync_inst (
    .mclk   (mclk),
    .arst_n (arst_n),
    .pin_in (pin_in),
    .level  (),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    rd = per_en & ~per_we;
    wr = per_en & per_we;
    mapped = cpu_addr <= pin_function_enable_pkg::PERIPH_HI ||
             (cpu_addr >= pin_function_enable_pkg::LOCK_LO &&
              cpu_addr <= pin_function_enable_pkg::RAM_HI) ||
             cpu_addr >= pin_function_enable_pkg::ROM_LO;
    lockable = cpu_addr >= pin_function_enable_pkg::LOCK_LO &&
               cpu_addr <= pin_function_enable_pkg::LOCK_HI;
    lock_next  = lock_reg;
    pinc_next  = pinc_reg;
    mbin_next  = mbin_reg;
    mbout_next = mbout_reg;
    rdata_next = 16'h0000;
    rst_next   = rst_reg;
    sys_next   = sys_reg;
    usr_next   = usr_reg;
    // our own drive echoes back; its edges would retrigger resets
    own_next  = {own_reg[1:0], ~poe_reg};
    edge_fall = pin_fall & ~|own_reg;
    edge_rise = pin_rise & ~|own_reg;
    // sources collected from outside and from software and pin
    rst_set = reset_event;
    if (wr && per_addr == pin_function_enable_pkg::CTRL_OFS) begin
      lock_next = per_wdata[pin_function_enable_pkg::CTRL_LOCK];
      rst_set[pin_function_enable_pkg::SRC_SWBOR] |=
        per_wdata[pin_function_enable_pkg::CTRL_SWBOR];
      rst_set[pin_function_enable_pkg::SRC_SWPOR] |=
        per_wdata[pin_function_enable_pkg::CTRL_SWPOR];
    end
    // pin low edge resets unless it serves as nmi input
    if (!pinc_reg[pin_function_enable_pkg::PIN_NMI_EN] && edge_fall) begin
      if (pinc_reg[pin_function_enable_pkg::PIN_SVSIN]) begin
        rst_set[pin_function_enable_pkg::SRC_SVSIN] = 1'b1;
      end else begin
        rst_set[pin_function_enable_pkg::SRC_PIN] = 1'b1;
      end
    end
    if (wr && per_addr == pin_function_enable_pkg::PIN_OFS) begin
      pinc_next = per_wdata[3:0];
    end
    if (wr && per_addr == pin_function_enable_pkg::MBOUT_OFS) begin
      mbout_next = per_wdata;
    end
    if (jtag_in_wr) begin
      mbin_next = jtag_in_data;
    end
    // reads answer next cycle; vector reads drop what they report
    if (rd) begin
      unique case (per_addr)
        pin_function_enable_pkg::RST_OFS: begin
          rdata_next = first_code(rst_reg);
          rst_next = rst_reg & ~first_mask(rst_reg);
        end
        pin_function_enable_pkg::SYS_OFS: begin
          rdata_next = first_code({7'h00, sys_reg});
          sys_next = sys_reg & ~4'(first_mask({7'h00, sys_reg}));
        end
        pin_function_enable_pkg::USER_OFS: begin
          rdata_next = first_code({8'h00, usr_reg});
          usr_next = usr_reg & ~3'(first_mask({8'h00, usr_reg}));
        end
        pin_function_enable_pkg::BUS_ERR_OFS: rdata_next = 16'h0000;
        pin_function_enable_pkg::CTRL_OFS: rdata_next = {15'h0000, lock_reg};
        pin_function_enable_pkg::PIN_OFS:  rdata_next = {12'h000, pinc_reg};
        pin_function_enable_pkg::MBIN_OFS: rdata_next = mbin_reg;
        pin_function_enable_pkg::MBOUT_OFS: rdata_next = mbout_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
    // a set in the clearing cycle wins over the clear
    rst_next = rst_next | rst_set;
    sys_next[pin_function_enable_pkg::SYS_SUPPLY] |= supply_drop;
    sys_next[pin_function_enable_pkg::SYS_VACANT] |=
      cpu_access & ~mapped;
    sys_next[pin_function_enable_pkg::SYS_MBIN]  |= jtag_in_wr;
    sys_next[pin_function_enable_pkg::SYS_MBOUT] |= jtag_out_rd;
    usr_next[pin_function_enable_pkg::USR_PIN] |=
      pinc_reg[pin_function_enable_pkg::PIN_NMI_EN] &
      (pinc_reg[pin_function_enable_pkg::PIN_EDGE] ? edge_fall
                                      : edge_rise);
    usr_next[pin_function_enable_pkg::USR_OSC] |= osc_fault;
    usr_next[pin_function_enable_pkg::USR_BUS] |= bus_fault;
    // classes: deepest wins, each request one cycle
    bor_next = |(rst_set & pin_function_enable_pkg::BOR_MASK);
    por_next = ~bor_next &
               |(rst_set & pin_function_enable_pkg::POR_MASK);
    puc_next = ~bor_next & ~por_next &
               |(rst_set & pin_function_enable_pkg::PUC_MASK);
    blk_next = cpu_access & cpu_write & lockable &
               lock_reg;
    // pin drives low as reset output, else may show monitor level
    poe_next = ~(bor_next | por_next | puc_next |
                 pinc_reg[pin_function_enable_pkg::PIN_SVMOUT]);
    pout_next = ~(bor_next | por_next | puc_next) &
                ~supply_low;
  end

  // ==========================================================
  // registers; flags survive class requests, only arst_n and vector reads clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_reg   <= 11'h000;
      sys_reg   <= 4'h0;
      usr_reg   <= 3'h0;
      lock_reg  <= pin_function_enable_pkg::LOCK_RST;
      pinc_reg  <= pin_function_enable_pkg::PIN_RST;
      mbin_reg  <= 16'h0000;
      mbout_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      bor_reg   <= 1'b0;
      por_reg   <= 1'b0;
      puc_reg   <= 1'b0;
      blk_reg   <= 1'b0;
      pout_reg  <= 1'b1;
      poe_reg   <= 1'b1;
      own_reg   <= 3'h0;
    end else begin
      rst_reg   <= rst_next;
      sys_reg   <= sys_next;
      usr_reg   <= usr_next;
      lock_reg  <= lock_next;
      pinc_reg  <= pinc_next;
      mbin_reg  <= mbin_next;
      mbout_reg <= mbout_next;
      rdata_reg <= rdata_next;
      bor_reg   <= bor_next;
      por_reg   <= por_next;
      puc_reg   <= puc_next;
      blk_reg   <= blk_next;
      pout_reg  <= pout_next;
      poe_reg   <= poe_next;
      own_reg   <= own_next;
    end
  end

  assign per_rdata     = rdata_reg;
  assign wr_block      = blk_reg;
  assign ram_locked    = lock_reg;
  assign bor_req       = bor_reg;
  assign por_req       = por_reg;
  assign puc_req       = puc_reg;
  assign jtag_out_data = mbout_reg;
  assign pin_out       = pout_reg;
  assign pin_oe_n      = poe_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  rst_idle_a: assert property (
    rd && per_addr == pin_function_enable_pkg::RST_OFS && rst_reg == 11'h000
    |=> per_rdata == 16'h0000) else $error("reset vector not idle");
  rst_code_a: assert property (
    rd && per_addr == pin_function_enable_pkg::RST_OFS && rst_reg != 11'h000
    |=> per_rdata >= 16'h0002 && per_rdata <= 16'h0016 &&
        !per_rdata[0]) else $error("reset code out of range");
  class_bor_a: assert property (
    reset_event[0] |=> bor_req && !puc_req && !por_req)
    else $error("brownout not deepest");
  sys_code_a: assert property (
    rd && per_addr == pin_function_enable_pkg::SYS_OFS && sys_reg == 4'ha
    |=> per_rdata == 16'h0004) else $error("system nmi order");
  user_code_a: assert property (
    rd && per_addr == pin_function_enable_pkg::USER_OFS && usr_reg == 3'h4
    |=> per_rdata == 16'h0006) else $error("user nmi code");
  mbox_in_a: assert property (
    jtag_in_wr |=> sys_reg[pin_function_enable_pkg::SYS_MBIN] &&
    mbin_reg == $past(jtag_in_data)) else $error("mailbox in");
  bus_fault_zero_a: assert property (
    rd && per_addr == pin_function_enable_pkg::BUS_ERR_OFS |=> per_rdata == 16'h0000)
    else $error("bus error vector not zero");
  pin_reset_a: assert property (
    edge_fall && !pinc_reg[pin_function_enable_pkg::PIN_NMI_EN] |=> bor_req && !pin_oe_n
    && !pin_out) else $error("pin reset not driven");
  lock_block_a: assert property (
    cpu_access && cpu_write && lockable && lock_reg |=> wr_block)
    else $error("locked write not blocked");
  nmi_edge_a: assert property (
    edge_fall && pinc_reg == 4'h3 |=> usr_reg[pin_function_enable_pkg::USR_PIN])
    else $error("pin nmi edge lost");
  vacant_a: assert property (
    cpu_access && !mapped |=> sys_reg[pin_function_enable_pkg::SYS_VACANT])
    else $error("vacant access missed");
  read_clr_a: assert property (
    rd && per_addr == pin_function_enable_pkg::SYS_OFS && sys_reg == 4'h1 &&
    !supply_drop && !jtag_in_wr && !jtag_out_rd && !cpu_access
    |=> sys_reg == 4'h0) else $error("vector read kept flag");

  rst_read_c: cover property (
    rd && per_addr == pin_function_enable_pkg::RST_OFS && rst_reg != 11'h000);
  puc_c: cover property (puc_req);
  nmi_pin_c: cover property (edge_fall && pinc_reg[0]);
  mbox_c: cover property (jtag_in_wr ##1 jtag_out_rd);
endmodule

// ---- tb/cpu_model.sv ----
// cpu side of the peripheral bus: word reads and writes
// assumes the unit takes a strobe on a rising edge, answers 1 cycle later
`timescale 1ns/1ps
module cpu_model (
  // clock
  input  wire logic        mclk,
  // peripheral bus towards the unit
  output logic             per_en,
  output logic             per_we,
  output logic      [15:0] per_addr,
  output logic      [15:0] per_wdata,
  input  wire logic [15:0] per_rdata
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    per_en    = 1'b0;
    per_we    = 1'b0;
    per_addr  = 16'h0000;
    per_wdata = 16'h0000;
  end
  // one strobe cycle; idle address and data are inverted so that a
  // stale value never looks like a fresh request
  task automatic access(input logic we, input logic [15:0] a,
                        input logic [15:0] d);
    @(posedge mclk);
    per_en    <= 1'b1;
    per_we    <= we;
    per_addr  <= a;
    per_wdata <= d;
    @(posedge mclk);
    per_en    <= 1'b0;
    per_we    <= 1'b0;
    per_addr  <= ~a;
    per_wdata <= ~d;
    #1;
  endtask
  // read data is registered and stands for the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    access(1'b0, a, 16'h0000);
    d = per_rdata;
  endtask
  // writes land on the taking edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    access(1'b1, a, d);
  endtask
endmodule

// ---- tb/pin_function_enable_unit_tb.sv ----
// bench for the reset and nmi vector unit, driven through the cpu model
// assumes pulses on event inputs last one cycle of mclk
`timescale 1ns/1ps
module pin_function_enable_unit_tb;
  // ==========================================================
  // unit ports and bench state
  logic        mclk, arst_n, per_en, per_we, cpu_access, cpu_write;
  logic [15:0] per_addr, per_wdata, per_rdata, cpu_addr, rd_val;
  logic [15:0] jtag_in_data, jtag_out_data;
  logic [10:0] reset_event;
  logic        supply_drop, osc_fault, bus_fault, jtag_in_wr, hit;
  logic        jtag_out_rd, wr_block, ram_locked, bor_req, por_req;
  logic        puc_req, pin_out, pin_oe_n, pin_drv, pin_wire;
  logic        supply_low;
  int          mismatches, cmp_count;
  // shared pin: the unit wins while it drives, else the bench level
  assign pin_wire = pin_oe_n ? pin_drv : pin_out;
  pin_function_enable_unit pin_function_enable_unit_inst (
    .mclk(mclk), .arst_n(arst_n), .per_en(per_en), .per_we(per_we),
    .per_addr(per_addr), .per_wdata(per_wdata), .per_rdata(per_rdata),
    .cpu_access(cpu_access), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
    .wr_block(wr_block), .ram_locked(ram_locked),
    .reset_event(reset_event), .supply_drop(supply_drop),
    .supply_low(supply_low), .osc_fault(osc_fault), .bus_fault(bus_fault),
    .bor_req(bor_req), .por_req(por_req), .puc_req(puc_req),
    .jtag_in_wr(jtag_in_wr), .jtag_in_data(jtag_in_data),
    .jtag_out_rd(jtag_out_rd), .jtag_out_data(jtag_out_data),
    .pin_in(pin_wire), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  cpu_model cpu_model_inst (
    .mclk(mclk), .per_en(per_en), .per_we(per_we), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_rdata(per_rdata));
  // ==========================================================
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // end the pulses driven at the last edge, then let outputs settle
  task automatic fire();
    @(posedge mclk);
    {reset_event, supply_drop, osc_fault, bus_fault} <= '0;
    {jtag_in_wr, jtag_out_rd, cpu_access, cpu_write} <= '0;
    #1;
  endtask
  task automatic rv(input logic [15:0] a, input logic [15:0] exp);
    cpu_model_inst.rd(a, rd_val);
    check(rd_val, exp);
  endtask
  // one cpu access to the memory watch, blocked or not
  task automatic mem(input logic we, input logic [15:0] a, input logic e);
    @(posedge mclk);
    cpu_access <= 1'b1;
    cpu_write  <= we;
    cpu_addr   <= a;
    fire();
    check({15'h0, wr_block}, {15'h0, e});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {arst_n, cpu_access, cpu_write, cpu_addr, reset_event} = '0;
    {supply_drop, osc_fault, bus_fault, jtag_in_wr, jtag_out_rd} = '0;
    jtag_in_data = 16'h0000;
    pin_drv = 1'b1;
    supply_low = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    // all vectors idle after reset, unmapped place reads zero
    rv(pin_function_enable_pkg::RST_OFS, 16'h0000);
    rv(pin_function_enable_pkg::SYS_OFS, 16'h0000);
    rv(pin_function_enable_pkg::USER_OFS, 16'h0000);
    rv(pin_function_enable_pkg::BUS_ERR_OFS, 16'h0000);
    rv(pin_function_enable_pkg::PIN_OFS, {12'h000, pin_function_enable_pkg::PIN_RST});
    rv(16'h01a0, 16'h0000);
    // every source at once: deepest class only, codes in order
    @(posedge mclk) reset_event <= 11'h7ff;
    fire();
    check({13'h0, bor_req, por_req, puc_req}, 16'h0004);
    for (int i = 0; i < 11; i++)
      rv(pin_function_enable_pkg::RST_OFS, 16'(2 * (i + 1)));
    rv(pin_function_enable_pkg::RST_OFS, 16'h0000);
    // each source alone: class pulse, pin driven low, code
    for (int i = 0; i < 11; i++) begin
      @(posedge mclk) reset_event <= 11'h001 << i;
      fire();
      check({13'h0, bor_req, por_req, puc_req},
            {13'h0, pin_function_enable_pkg::BOR_MASK[i], pin_function_enable_pkg::POR_MASK[i],
             pin_function_enable_pkg::PUC_MASK[i]});
      check({14'h0, pin_oe_n, pin_out}, 16'h0000);
      rv(pin_function_enable_pkg::RST_OFS, 16'(2 * (i + 1)));
    end
    // software brownout and power-on requests
    cpu_model_inst.wr(pin_function_enable_pkg::CTRL_OFS, 16'h0002);
    rv(pin_function_enable_pkg::RST_OFS, 16'h0008);
    cpu_model_inst.wr(pin_function_enable_pkg::CTRL_OFS, 16'h0004);
    rv(pin_function_enable_pkg::RST_OFS, 16'h000c);
    rv(pin_function_enable_pkg::CTRL_OFS, 16'h0000);
    // system nmi: implemented place is quiet, then all four at once
    mem(1'b0, 16'h0200, 1'b0);
    rv(pin_function_enable_pkg::SYS_OFS, 16'h0000);
    @(posedge mclk);
    {supply_drop, cpu_access, jtag_in_wr, jtag_out_rd} <= 4'hf;
    cpu_addr <= 16'h1000;
    jtag_in_data <= 16'h5a3c;
    fire();
    for (int i = 1; i < 6; i++)
      rv(pin_function_enable_pkg::SYS_OFS, i < 5 ? 16'(2 * i) : 16'h0000);
    rv(pin_function_enable_pkg::MBIN_OFS, 16'h5a3c);
    cpu_model_inst.wr(pin_function_enable_pkg::MBOUT_OFS, 16'hc3a5);
    check(jtag_out_data, 16'hc3a5);
    // vacant and mailbox-out together, then supply monitor alone
    @(posedge mclk);
    {cpu_access, jtag_out_rd} <= 2'b11;
    fire();
    rv(pin_function_enable_pkg::SYS_OFS, 16'h0004);
    rv(pin_function_enable_pkg::SYS_OFS, 16'h0008);
    @(posedge mclk) supply_drop <= 1'b1;
    fire();
    rv(pin_function_enable_pkg::SYS_OFS, 16'h0002);
    rv(pin_function_enable_pkg::SYS_OFS, 16'h0000);
    // pin nmi on either edge, never a reset
    for (int e = 0; e < 2; e++) begin
      cpu_model_inst.wr(pin_function_enable_pkg::PIN_OFS, 16'(1 + 2 * e));
      @(posedge mclk) pin_drv <= 1'b0;
      repeat (6) @(posedge mclk);
      rv(pin_function_enable_pkg::USER_OFS, e ? 16'h0002 : 16'h0000);
      @(posedge mclk) pin_drv <= 1'b1;
      repeat (6) @(posedge mclk);
      rv(pin_function_enable_pkg::USER_OFS, e ? 16'h0000 : 16'h0002);
    end
    rv(pin_function_enable_pkg::RST_OFS, 16'h0000);
    // user nmi priority; bus error vector stays idle
    @(posedge mclk) {pin_drv, osc_fault, bus_fault} <= 3'b011;
    fire();
    repeat (6) @(posedge mclk);
    for (int i = 1; i < 5; i++)
      rv(pin_function_enable_pkg::USER_OFS, i < 4 ? 16'(2 * i) : 16'h0000);
    rv(pin_function_enable_pkg::BUS_ERR_OFS, 16'h0000);
    // pin as reset input, plain and with the supervisor bit
    for (int s = 0; s < 2; s++) begin
      cpu_model_inst.wr(pin_function_enable_pkg::PIN_OFS, 16'(8 * s));
      @(posedge mclk) pin_drv <= 1'b1;
      repeat (6) @(posedge mclk);
      rv(pin_function_enable_pkg::RST_OFS, 16'h0000);
      @(posedge mclk) pin_drv <= 1'b0;
      hit = 1'b0;
      for (int k = 0; k < 10 && hit !== 1'b1; k++) begin
        @(posedge mclk);
        #1;
        hit = bor_req;
      end
      if (hit !== 1'b1) begin
        mismatches++;
        close_out();
      end
      rv(pin_function_enable_pkg::RST_OFS, s ? 16'h0004 : 16'h0006);
    end
    // ram lock blocks writes to the lockable range only
    cpu_model_inst.wr(pin_function_enable_pkg::CTRL_OFS, 16'h0001);
    check({15'h0, ram_locked}, 16'h0001);
    rv(pin_function_enable_pkg::CTRL_OFS, 16'h0001);
    mem(1'b1, 16'h1c00, 1'b1);
    mem(1'b1, 16'h237f, 1'b1);
    mem(1'b1, 16'h2380, 1'b0);
    mem(1'b0, 16'h1c00, 1'b0);
    cpu_model_inst.wr(pin_function_enable_pkg::CTRL_OFS, 16'h0000);
    mem(1'b1, 16'h1c00, 1'b0);
    // monitor output: pin shows the supply level and never resets
    cpu_model_inst.wr(pin_function_enable_pkg::PIN_OFS, 16'h0004);
    @(posedge mclk) supply_low <= 1'b1;
    @(posedge mclk);
    #1;
    check({14'h0, pin_oe_n, pin_out}, 16'h0000);
    @(posedge mclk) supply_low <= 1'b0;
    @(posedge mclk);
    #1;
    check({14'h0, pin_oe_n, pin_out}, 16'h0001);
    @(posedge mclk) pin_drv <= 1'b1;
    cpu_model_inst.wr(pin_function_enable_pkg::PIN_OFS, 16'h0000);
    repeat (6) @(posedge mclk);
    rv(pin_function_enable_pkg::RST_OFS, 16'h0000);
    close_out();
  end
endmodule
